// ---- rtl/irq_latch_gate.sv ----
/*
 Latches one controller interrupt and selects how the latched copy
 combines with the live one.
 Assumes core_irq and irq_ack come from logic on the same clock.
*/
`timescale 1ns/1ps

module irq_latch_gate (
   input wire logic clk,
   input wire logic reset,
   input wire logic core_irq,
   input wire logic irq_ack,
   input wire logic latch_only,
   output logic irq_out,
   output logic irq_event
);

   logic prev_reg;
   logic latch_reg;
   logic out_reg;
   logic event_reg;
   wire rise = core_irq && !prev_reg;
   // Set wins over acknowledge in the same cycle
   wire latch_next = rise || (latch_reg && !irq_ack);
   wire out_next = latch_only ? latch_reg : (core_irq && latch_reg);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prev_reg <= 1'b0;
         latch_reg <= 1'b0;
         out_reg <= 1'b0;
         event_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= core_irq;
         latch_reg <= latch_next;
         out_reg <= out_next;
         event_reg <= rise;
      end
   end

   assign irq_out = out_reg;
   assign irq_event = event_reg;

   // ==========================================================
   // Checks
   irq_select_a : assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> irq_out == ($past(latch_only) ? $past(latch_reg)
                           : ($past(core_irq) && $past(latch_reg))))
      else $error("interrupt output does not follow latch select");

   latch_hold_a : assert property (@(posedge clk) disable iff (reset)
      (core_irq && !prev_reg) |=> latch_reg ##1 (latch_reg || $past(irq_ack)))
      else $error("latched interrupt lost without acknowledge");

endmodule

// ---- rtl/kbd_gate_defs.svh ----
/*
 Constants for the keyboard gate configuration block: register indexes,
 reset values, idle line levels and bus answer codes.
 Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef KBD_GATE_DEFS_SVH
`define KBD_GATE_DEFS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define IDX_LDN 8'h07
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define IDX_KBD_CFG 8'hF0
`define IDX_RSVD_FIRST 8'hF1
`define IDX_RSVD_LAST 8'hFF

// ==========================================================
// Values
`define LDN_KBD 8'h07
`define LDN_RESET 8'h00
`define CFG_RESET 8'h00
`define CFG_WRITABLE 8'hFC
`define IRQ_RESET 4'h0
`define LINE_IDLE 2'h3
`define RESP_OKAY 2'h0
`define SPACE_HIGH 2'h0
`define WORD_ZERO 32'h0000_0000

`endif

// ---- rtl/kbd_gate_pkg.sv ----
/*
 Types shared by the keyboard gate configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package kbd_gate_pkg;

   // ==========================================================
   // Configuration register layout, bit 7 down to bit 0
   typedef struct packed {
      logic port_pol;
      logic mouse_iso;
      logic kbd_iso;
      logic mouse_irq_latch_sel;
      logic keyboard_irq_latch_sel;
      logic port92_en;
      logic [1:0] rsvd;
   } kbd_cfg_type;

   // ==========================================================
   // One PS/2 port, clock and data
   typedef struct packed {
      logic clk;
      logic data;
   } ps2_lines_type;

   // ==========================================================
   // Interrupt status and mask layout
   typedef struct packed {
      logic mouse_wake;
      logic kbd_wake;
      logic mouse_irq;
      logic kbd_irq;
   } irq_events_type;

endpackage

// ---- rtl/kbd_reset_gate_config.sv ----
/*
 Keyboard controller configuration register with its AXI4-Lite slave,
 PS/2 line isolation, interrupt latch selection and event interrupts.
 Assumes PS/2 pins are asynchronous; core signals share clk.
*/
`timescale 1ns/1ps
`include "kbd_gate_defs.svh"

module kbd_reset_gate_config (
   input wire logic clk,
   input wire logic reset,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire kbd_gate_pkg::ps2_lines_type kbd_pins,
   input wire kbd_gate_pkg::ps2_lines_type mouse_pins,
   output kbd_gate_pkg::ps2_lines_type kbd_to_core,
   output kbd_gate_pkg::ps2_lines_type mouse_to_core,
   output logic keyboard_wake_data,
   output logic mouse_wake_data,
   input wire logic ctrl_port_core,
   output logic ctrl_port_out_line,
   input wire logic core_keyboard_irq,
   input wire logic core_mouse_irq,
   input wire logic keyboard_irq_ack,
   input wire logic mouse_irq_ack,
   output logic keyboard_irq,
   output logic mouse_irq,
   output logic port92_enable,
   output logic irq
);
   import kbd_gate_pkg::*;

   // ==========================================================
   // Address helpers
   function automatic logic [7:0] reg_index(input logic [11:0] addr);
      reg_index = addr[9:2];
   endfunction

   function automatic logic in_space(input logic [11:0] addr);
      in_space = (addr[11:10] == `SPACE_HIGH);
   endfunction

   // ==========================================================
   // State
   kbd_cfg_type cfg_reg;
   logic [7:0] ldn_reg;
   irq_events_type status_reg;
   irq_events_type mask_reg;
   logic irq_reg;

   logic aw_full_reg;
   logic w_full_reg;
   logic [11:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;

   ps2_lines_type kbd_meta_reg;
   ps2_lines_type kbd_sync_reg;
   ps2_lines_type mouse_meta_reg;
   ps2_lines_type mouse_sync_reg;
   logic kbd_data_prev_reg;
   logic mouse_data_prev_reg;

   ps2_lines_type kbd_core_reg;
   ps2_lines_type mouse_core_reg;
   logic kbd_wake_reg;
   logic mouse_wake_reg;
   logic port_out_reg;
   logic port92_reg;

   // ==========================================================
   // Write channel decode
   wire aw_take = awvalid && awready_reg;
   wire w_take = wvalid && wready_reg;
   wire wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
   wire aw_full_next = (aw_full_reg || aw_take) && !wr_go;
   wire w_full_next = (w_full_reg || w_take) && !wr_go;
   wire bvalid_next = wr_go || (bvalid_reg && !bready);
   wire [7:0] wr_idx = reg_index(aw_addr_reg);
   // Only the low byte lane carries register bits
   wire wr_ok = wr_go && in_space(aw_addr_reg) && w_strb_reg[0];
   wire kbd_selected = (ldn_reg == `LDN_KBD);
   wire wr_cfg = wr_ok && kbd_selected && (wr_idx == `IDX_KBD_CFG);
   wire wr_ldn = wr_ok && (wr_idx == `IDX_LDN);
   wire wr_status = wr_ok && (wr_idx == `IDX_IRQ_STATUS);
   wire wr_mask = wr_ok && (wr_idx == `IDX_IRQ_MASK);

   // Reserved bits never take a written value
   wire kbd_cfg_type cfg_next = wr_cfg ? (w_data_reg[7:0] & `CFG_WRITABLE) : cfg_reg;

   // ==========================================================
   // Read channel decode
   wire ar_take = arvalid && arready_reg;
   wire rvalid_next = ar_take || (rvalid_reg && !rready);
   wire [7:0] rd_idx = reg_index(araddr);
   wire rd_space = in_space(araddr);
   wire rd_rsvd = kbd_selected && (rd_idx >= `IDX_RSVD_FIRST);
   wire [31:0] rd_value =
      !rd_space ? `WORD_ZERO :
      (rd_idx == `IDX_LDN) ? {24'h00_0000, ldn_reg} :
      (rd_idx == `IDX_IRQ_STATUS) ? {28'h000_0000, status_reg} :
      (rd_idx == `IDX_IRQ_MASK) ? {28'h000_0000, mask_reg} :
      (kbd_selected && rd_idx == `IDX_KBD_CFG) ? {24'h00_0000, cfg_reg} :
      `WORD_ZERO;

   // ==========================================================
   // Interrupt events
   irq_events_type events;
   wire kbd_irq_event;
   wire mouse_irq_event;
   assign events.kbd_irq = kbd_irq_event;
   assign events.mouse_irq = mouse_irq_event;
   // Wake events look only at the second synchroniser stage
   assign events.kbd_wake = kbd_data_prev_reg && !kbd_sync_reg.data;
   assign events.mouse_wake = mouse_data_prev_reg && !mouse_sync_reg.data;
   wire [3:0] clear_bits = wr_status ? w_data_reg[3:0] : `IRQ_RESET;
   // Set wins over write-one-to-clear
   wire irq_events_type status_next = (status_reg & ~clear_bits) | events;
   wire irq_events_type mask_next = wr_mask ? w_data_reg[3:0] : mask_reg;
   wire irq_next = |(status_reg & mask_reg);

   // ==========================================================
   // Controlled signals
   wire ps2_lines_type kbd_core_next = cfg_reg.kbd_iso ? `LINE_IDLE : kbd_sync_reg;
   wire ps2_lines_type mouse_core_next =
      cfg_reg.mouse_iso ? `LINE_IDLE : mouse_sync_reg;
   wire port_out_next = cfg_reg.port_pol ? ctrl_port_core : !ctrl_port_core;

   // ==========================================================
   // Bus registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= `WORD_ZERO;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready_reg <= !aw_full_next;
         wready_reg <= !w_full_next;
         bvalid_reg <= bvalid_next;
         arready_reg <= !rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take)
            rdata_reg <= rd_value;
      end
   end

   always_ff @(posedge clk)
   begin
      if (aw_take)
         aw_addr_reg <= awaddr;
      if (w_take)
      begin
         w_data_reg <= wdata;
         w_strb_reg <= wstrb;
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cfg_reg <= `CFG_RESET;
         ldn_reg <= `LDN_RESET;
         status_reg <= `IRQ_RESET;
         mask_reg <= `IRQ_RESET;
         irq_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         if (wr_ldn)
            ldn_reg <= w_data_reg[7:0];
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   // ==========================================================
   // Pin synchronisers and controlled outputs
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         kbd_meta_reg <= `LINE_IDLE;
         kbd_sync_reg <= `LINE_IDLE;
         mouse_meta_reg <= `LINE_IDLE;
         mouse_sync_reg <= `LINE_IDLE;
         kbd_data_prev_reg <= 1'b1;
         mouse_data_prev_reg <= 1'b1;
      end
      else
      begin
         kbd_meta_reg <= kbd_pins;
         kbd_sync_reg <= kbd_meta_reg;
         mouse_meta_reg <= mouse_pins;
         mouse_sync_reg <= mouse_meta_reg;
         kbd_data_prev_reg <= kbd_sync_reg.data;
         mouse_data_prev_reg <= mouse_sync_reg.data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         kbd_core_reg <= `LINE_IDLE;
         mouse_core_reg <= `LINE_IDLE;
         kbd_wake_reg <= 1'b1;
         mouse_wake_reg <= 1'b1;
         port_out_reg <= 1'b1;
         port92_reg <= 1'b0;
      end
      else
      begin
         kbd_core_reg <= kbd_core_next;
         mouse_core_reg <= mouse_core_next;
         // Wake paths bypass isolation on purpose
         kbd_wake_reg <= kbd_sync_reg.data;
         mouse_wake_reg <= mouse_sync_reg.data;
         port_out_reg <= port_out_next;
         port92_reg <= cfg_reg.port92_en;
      end
   end

   // ==========================================================
   // Interrupt latches
   irq_latch_gate kbd_latch (
      .clk(clk),
      .reset(reset),
      .core_irq(core_keyboard_irq),
      .irq_ack(keyboard_irq_ack),
      .latch_only(cfg_reg.keyboard_irq_latch_sel),
      .irq_out(keyboard_irq),
      .irq_event(kbd_irq_event)
   );

   irq_latch_gate mouse_latch (
      .clk(clk),
      .reset(reset),
      .core_irq(core_mouse_irq),
      .irq_ack(mouse_irq_ack),
      .latch_only(cfg_reg.mouse_irq_latch_sel),
      .irq_out(mouse_irq),
      .irq_event(mouse_irq_event)
   );

   // ==========================================================
   // Outputs
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bresp = `RESP_OKAY;
   assign bvalid = bvalid_reg;
   assign arready = arready_reg;
   assign rdata = rdata_reg;
   assign rresp = `RESP_OKAY;
   assign rvalid = rvalid_reg;
   assign kbd_to_core = kbd_core_reg;
   assign mouse_to_core = mouse_core_reg;
   assign keyboard_wake_data = kbd_wake_reg;
   assign mouse_wake_data = mouse_wake_reg;
   assign ctrl_port_out_line = port_out_reg;
   assign port92_enable = port92_reg;
   assign irq = irq_reg;

   // ==========================================================
   // Checks
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   cfg_write_ldn_a : assert property (
      wr_go && in_space(aw_addr_reg) && w_strb_reg[0] && (wr_idx == `IDX_KBD_CFG)
      |=> (cfg_reg == ($past(kbd_selected) ? ($past(w_data_reg[7:0]) & `CFG_WRITABLE)
                       : $past(cfg_reg))))
      else $error("config write not gated by logical device");

   port_polarity_a : assert property (
      1'b1 |=> ctrl_port_out_line ==
         ($past(cfg_reg.port_pol) ? $past(ctrl_port_core) : !$past(ctrl_port_core)))
      else $error("port output polarity wrong");

   mouse_isolate_a : assert property (
      cfg_reg.mouse_iso |=> mouse_to_core == `LINE_IDLE)
      else $error("mouse lines reach core while isolated");

   mouse_pass_a : assert property (
      !cfg_reg.mouse_iso |=> mouse_to_core == $past(mouse_sync_reg))
      else $error("mouse lines not passed through");

   mouse_wake_a : assert property (
      1'b1 |-> ##3 mouse_wake_data == $past(mouse_pins.data, 3))
      else $error("mouse wake data gated");

   kbd_isolate_a : assert property (
      cfg_reg.kbd_iso |=> kbd_to_core == `LINE_IDLE)
      else $error("keyboard lines reach core while isolated");

   kbd_pass_a : assert property (
      !cfg_reg.kbd_iso |=> kbd_to_core == $past(kbd_sync_reg))
      else $error("keyboard lines not passed through");

   kbd_wake_a : assert property (
      1'b1 |-> ##3 keyboard_wake_data == $past(kbd_pins.data, 3))
      else $error("keyboard wake data gated");

   port92_follow_a : assert property (
      wr_cfg |-> ##2 port92_enable == $past(w_data_reg[2], 2))
      else $error("port 92 enable does not follow config");

   rsvd_read_a : assert property (
      ar_take && rd_space && rd_rsvd |=> rvalid && rdata == `WORD_ZERO)
      else $error("reserved index read not zero");

   rsvd_bits_a : assert property (
      wr_cfg |=> cfg_reg.rsvd == 2'h0 && cfg_reg[7:2] == $past(w_data_reg[7:2]))
      else $error("reserved config bits took a write");

   rsvd_read_bits_a : assert property (
      ar_take && rd_space && kbd_selected && (rd_idx == `IDX_KBD_CFG) |=> rdata[1:0] == 2'h0)
      else $error("reserved config bits read back nonzero");

endmodule

// ---- tb/kbd_reset_gate_config_test.sv ----
/*
 Self-checking bench: AXI4-Lite register access, isolation, latch select, events.
 Assumes the design and the far side model share one 50 MHz clock.
*/
`timescale 1ns/1ps

module kbd_reset_gate_config_test;
   import kbd_gate_pkg::*;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'h1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   ps2_lines_type kbd_pins, mouse_pins, kbd_to_core, mouse_to_core;
   ps2_lines_type kbd_want = 2'h3, mouse_want = 2'h3;
   logic [4:0] core_want = 5'h00;
   logic ctrl_port_core, core_keyboard_irq, core_mouse_irq, keyboard_irq_ack, mouse_irq_ack;
   logic keyboard_wake_data, mouse_wake_data, ctrl_port_out_line;
   logic keyboard_irq, mouse_irq, port92_enable, irq;
   int failures = 0;
   int total_checks = 0;
   int i;

   // Byte addresses are four times the register index
   localparam logic [11:0] A_LDN = 12'h01C, A_STAT = 12'h080, A_MASK = 12'h084;
   localparam logic [11:0] A_CFG = 12'h3C0;

   initial
   begin
      forever #10 clk = ~clk;
   end

   kbd_reset_gate_config kbd_reset_gate_config_i (.clk(clk), .reset(reset),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
      .kbd_pins(kbd_pins), .mouse_pins(mouse_pins), .kbd_to_core(kbd_to_core),
      .mouse_to_core(mouse_to_core), .keyboard_wake_data(keyboard_wake_data),
      .mouse_wake_data(mouse_wake_data), .ctrl_port_core(ctrl_port_core),
      .ctrl_port_out_line(ctrl_port_out_line), .core_keyboard_irq(core_keyboard_irq),
      .core_mouse_irq(core_mouse_irq), .keyboard_irq_ack(keyboard_irq_ack),
      .mouse_irq_ack(mouse_irq_ack), .keyboard_irq(keyboard_irq), .mouse_irq(mouse_irq),
      .port92_enable(port92_enable), .irq(irq));

   ps2_core_model ps2_core_model_i (.clk(clk), .kbd_want(kbd_want),
      .mouse_want(mouse_want), .core_want(core_want), .kbd_pins(kbd_pins),
      .mouse_pins(mouse_pins), .ctrl_port_core(ctrl_port_core),
      .core_keyboard_irq(core_keyboard_irq), .core_mouse_irq(core_mouse_irq),
      .keyboard_irq_ack(keyboard_irq_ack), .mouse_irq_ack(mouse_irq_ack));

   // ==========================================================
   // Reporting
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic bad(input string msg);
      failures++;
      $display("BAD at %0t: %s", $time, msg);
   endtask

   task automatic check_word(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
         bad($sformatf("word %h expected %h", g, e));
   endtask

   task automatic check_lines(input logic [5:0] g, input logic [5:0] e);
      total_checks++;
      if (g !== e)
         bad($sformatf("lines %b expected %b", g, e));
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ==========================================================
   // Bus master; bready and rready stay high throughout
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 100)
      begin
         bad("write timeout");
         give_verdict();
      end
      check_word({30'h0, bresp}, 32'h0000_0000);
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      d = rdata;
      check_word({30'h0, rresp}, 32'h0000_0000);
      if (n == 100)
      begin
         bad("read timeout");
         give_verdict();
      end
   endtask

   task automatic read_check(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      axi_read(a, d);
      check_word(d, e);
   endtask

   // Pin view: {kbd_to_core, mouse_to_core, kbd wake, mouse wake}
   function automatic logic [5:0] pins_now();
      return {kbd_to_core, mouse_to_core, keyboard_wake_data, mouse_wake_data};
   endfunction

   // ==========================================================
   // Scenarios
   initial
   begin
      tick(10);
      reset <= 1'b0;
      tick(2);
      read_check(A_CFG, 32'h0000_0000);
      read_check(A_LDN, 32'h0000_0000);
      read_check(12'h800, 32'h0000_0000);
      check_word({29'h0, ctrl_port_out_line, port92_enable, irq}, 32'h0000_0004);
      axi_write(A_LDN, 32'h0000_0007);
      read_check(A_CFG, 32'h0000_0000);
      axi_write(A_CFG, 32'hFFFF_FFFF);
      read_check(A_CFG, 32'h0000_00FC);
      axi_write(A_LDN, 32'h0000_0000);
      axi_write(A_CFG, 32'h0000_0000);
      read_check(A_CFG, 32'h0000_0000);
      axi_write(A_LDN, 32'h0000_0007);
      read_check(A_CFG, 32'h0000_00FC);
      for (i = 12'h3C4; i <= 12'h3FC; i += 4)
      begin
         axi_write(i[11:0], 32'h0000_00FF);
         read_check(i[11:0], 32'h0000_0000);
      end
      // Latch select: latched only, then live AND latched
      axi_write(A_STAT, 32'h0000_000F);
      axi_write(A_MASK, 32'h0000_0000);
      axi_write(A_CFG, 32'h0000_0018);
      core_want <= 5'h06;
      tick(4);
      core_want <= 5'h00;
      tick(4);
      check_word({30'h0, keyboard_irq, mouse_irq}, 32'h0000_0003);
      read_check(A_STAT, 32'h0000_0003);
      check_word({31'h0, irq}, 32'h0000_0000);
      axi_write(A_MASK, 32'h0000_0001);
      tick(3);
      check_word({31'h0, irq}, 32'h0000_0001);
      axi_write(A_STAT, 32'h0000_0001);
      tick(3);
      read_check(A_STAT, 32'h0000_0002);
      check_word({31'h0, irq}, 32'h0000_0000);
      axi_write(A_CFG, 32'h0000_0000);
      tick(3);
      check_word({30'h0, keyboard_irq, mouse_irq}, 32'h0000_0000);
      core_want <= 5'h06;
      tick(4);
      check_word({30'h0, keyboard_irq, mouse_irq}, 32'h0000_0003);
      core_want <= 5'h18;
      tick(4);
      core_want <= 5'h00;
      axi_write(A_CFG, 32'h0000_0018);
      tick(3);
      check_word({30'h0, keyboard_irq, mouse_irq}, 32'h0000_0000);
      // Isolation, polarity and port 92 enable
      axi_write(A_CFG, 32'h0000_00FC);
      kbd_want <= 2'h0;
      mouse_want <= 2'h0;
      core_want <= 5'h01;
      tick(5);
      check_lines(pins_now(), 6'b11_11_00);
      check_word({30'h0, ctrl_port_out_line, port92_enable}, 32'h0000_0003);
      read_check(A_STAT, 32'h0000_000F);
      axi_write(A_MASK, 32'h0000_0008);
      tick(3);
      check_word({31'h0, irq}, 32'h0000_0001);
      axi_write(A_CFG, 32'h0000_0000);
      kbd_want <= 2'h2;
      mouse_want <= 2'h1;
      tick(5);
      check_lines(pins_now(), 6'b10_01_01);
      check_word({30'h0, ctrl_port_out_line, port92_enable}, 32'h0000_0000);
      axi_write(A_CFG, 32'h0000_0040);
      tick(2);
      check_lines(pins_now(), 6'b10_11_01);
      // A write without byte lane 0 must leave the register alone
      wstrb <= 4'h0;
      axi_write(A_CFG, 32'h0000_0000);
      wstrb <= 4'h1;
      read_check(A_CFG, 32'h0000_0040);
      give_verdict();
   end

endmodule

// ---- tb/ps2_core_model.sv ----
/*
 Behavioural far side: keyboard controller core plus PS/2 keyboard and mouse.
 Assumes the bench sets the wanted levels just after a rising clock edge.
*/
`timescale 1ns/1ps

module ps2_core_model (
   input wire logic clk,
   input wire kbd_gate_pkg::ps2_lines_type kbd_want,
   input wire kbd_gate_pkg::ps2_lines_type mouse_want,
   input wire logic [4:0] core_want,
   output kbd_gate_pkg::ps2_lines_type kbd_pins,
   output kbd_gate_pkg::ps2_lines_type mouse_pins,
   output logic ctrl_port_core,
   output logic core_keyboard_irq,
   output logic core_mouse_irq,
   output logic keyboard_irq_ack,
   output logic mouse_irq_ack
);
   import kbd_gate_pkg::*;

   // ==========================================================
   // core_want is {mouse ack, kbd ack, mouse irq, kbd irq, port line}
   logic [1:0] ack_seen;

   // Pull-ups hold idle PS/2 lines high
   initial
   begin
      kbd_pins = 2'h3;
      mouse_pins = 2'h3;
      {mouse_irq_ack, keyboard_irq_ack, core_mouse_irq, core_keyboard_irq} = 4'h0;
      ctrl_port_core = 1'b0;
      ack_seen = 2'h0;
   end

   // Acks are one-cycle pulses on each new request, as the core gives them
   always @(posedge clk)
   begin
      kbd_pins <= kbd_want;
      mouse_pins <= mouse_want;
      {core_mouse_irq, core_keyboard_irq, ctrl_port_core} <= core_want[2:0];
      {mouse_irq_ack, keyboard_irq_ack} <= core_want[4:3] & ~ack_seen;
      ack_seen <= core_want[4:3];
   end

endmodule
